/* File: hdl/ptp_timestamp_unit_100g.sv */
// How it works
// - Every received frame gets a timestamp
// - Sample lane 0 words, skip dead slot
// - Keep start-of-packet timestamps, report their lane
// - Export every lane alignment fill level
// - Per-frame command selects timestamp action
// - 2-step corrected; 1-step uses latency adjust
// - Ordinary clock returns full 80-bit stamp
// - Transparent clock returns 64 bits, upper zero
// - Ordinary 1-step writes 80 bits at offset
// - Transparent 1-step adds stamp to field
// - 1-step for raw, UDP IPv4/IPv6 frames
// - UDP checksum patched incrementally
// - FCS computed after all modifications
// - 2-step stamp returned with its tag
// - No-operation frames get nothing
// - Gearbox sequence tracks residual bits
// - Add period times n/32 to 2-step stamp
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
module ptp_timestamp_unit_100g (
  input  wire logic         i_mclk,
  input  wire logic         i_rst_n,
  input  wire logic         i_ce,
  input  wire logic [7:0]   i_awaddr,
  input  wire logic         i_awvalid,
  output logic              o_awready,
  input  wire logic [31:0]  i_wdata,
  input  wire logic [3:0]   i_wstrb,
  input  wire logic         i_wvalid,
  output logic              o_wready,
  output logic [1:0]        o_bresp,
  output logic              o_bvalid,
  input  wire logic         i_bready,
  input  wire logic [7:0]   i_araddr,
  input  wire logic         i_arvalid,
  output logic              o_arready,
  output logic [31:0]       o_rdata,
  output logic [1:0]        o_rresp,
  output logic              o_rvalid,
  input  wire logic         i_rready,
  input  wire logic         i_rx_gb_valid,
  input  wire logic [79:0]  i_rx_timer,
  input  wire logic         i_rx_dec_valid,
  input  wire logic         i_rx_dec_sop,
  input  wire logic         i_rx_dec_eop,
  input  wire logic [4:0]   i_rx_dec_lane,
  input  wire logic [63:0]  i_rx_dec_data,
  input  wire logic [139:0] i_rx_fill,
  output logic              o_rx_valid,
  output logic              o_rx_sop,
  output logic              o_rx_eop,
  output logic [63:0]       o_rx_data,
  output logic [79:0]       o_rx_tstamp,
  output logic [4:0]        o_rx_pcslane,
  output logic [139:0]      o_rx_fill,
  input  wire logic [31:0]  i_tx_data,
  input  wire logic         i_tx_valid,
  input  wire logic         i_tx_sop,
  input  wire logic         i_tx_eop,
  output logic              o_tx_in_ready,
  input  wire logic [1:0]   i_tx_timestamp_command_op,
  input  wire logic         i_tx_timestamp_command_udp,
  input  wire logic [15:0]  i_tx_timestamp_command_ts_off,
  input  wire logic [15:0]  i_tx_timestamp_command_cs_off,
  input  wire logic [15:0]  i_tx_timestamp_command_tag,
  input  wire logic [79:0]  i_tx_tod,
  input  wire logic [4:0]   i_tx_gb_seq,
  output logic              o_tx_valid,
  output logic              o_tx_sop,
  output logic              o_tx_eop,
  output logic [31:0]       o_tx_data,
  output logic              o_tx_ts_valid,
  output logic [79:0]       o_tx_ts,
  output logic [15:0]       o_tx_tag
);
  // Ones-complement 16-bit add with end-around carry
  function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0, s[16]};
  endfunction : oc_add

  // FCS over one word, first byte in the top lane, bits LSB first
  function automatic logic [31:0] crc_w(input logic [31:0] c, input logic [31:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 32; i++)
    begin
      r = (r[0] ^ d[24 - 8 * (i / 8) + (i % 8)]) ? ((r >> 1) ^ ptp_ts_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_w

  logic                  tc_r;        // Transparent clock mode
  logic [7:0]            lat_r;       // 1-step latency adjust, ns
  logic [15:0]           rx_cnt_r;    // Received starts
  logic [15:0]           tx_cnt_r;    // Sent frames
  logic                  aw_hold_r;   // Write address held
  logic                  w_hold_r;    // Write data held
  logic [7:0]            awaddr_r;    // Held write address
  logic [31:0]           wdata_r;     // Held write data
  logic [3:0]            wstrb_r;     // Held byte enables
  logic                  wr_go;       // Both halves present
  logic [5:0]            gb_cnt_r;    // Position in 33-slot gearbox cycle
  logic [79:0]           rx_ts_r;     // Latest lane 0 sample
  ptp_ts_pkg::tx_state_t st_r;        // Transmit sequencer
  logic [6:0]            wa_r;        // Words stored
  logic [6:0]            ra_r;        // Words sent
  logic [1:0]            op_r;        // Frame command
  logic                  udp_r;       // Checksum present
  logic [7:0]            tsoff_r;     // Stamp or field offset
  logic [7:0]            csoff_r;     // Checksum offset
  logic [79:0]           ts1_r;       // Insertion value
  logic [79:0]           old_r;       // Bytes before patch, zero in ordinary mode
  logic [79:0]           new_r;       // Bytes after patch
  logic [31:0]           crc_r;       // Running FCS
  logic                  mod_done_r;  // Modifications finished
  logic [7:0]            mem [256];   // Frame store, bytes
  logic                  tx_take;     // Input word accepted
  logic                  sop_take;    // First word accepted
  logic [31:0]           comp;        // Gearbox jitter term
  logic [79:0]           ts1_full;    // 1-step stamp
  logic [79:0]           ts2_full;    // 2-step stamp
  logic [63:0]           cf_old;      // Field read from store
  logic [63:0]           cf_new;      // Field plus stamp
  logic [15:0]           csum_new;    // Patched checksum
  logic [6:0]            wptr;        // Word slot for incoming data
  logic [31:0]           rd_word;     // Word leaving the store

  // Write channel: each half parked until both have arrived
  assign o_awready = !aw_hold_r;
  assign o_wready  = !w_hold_r;
  assign wr_go     = aw_hold_r && w_hold_r && !o_bvalid;
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0;
      wstrb_r   <= 4'h0;
      o_bvalid  <= 1'b0;
      o_bresp   <= ptp_ts_pkg::RESP_OK;
    end
    else if (i_ce)
    begin
      if (i_awvalid && o_awready)
      begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= i_awaddr;
      end
      else if (wr_go)
        aw_hold_r <= 1'b0;
      if (i_wvalid && o_wready)
      begin
        w_hold_r <= 1'b1;
        wdata_r  <= i_wdata;
        wstrb_r  <= i_wstrb;
      end
      else if (wr_go)
        w_hold_r <= 1'b0;
      // Answer, error for unmapped words
      if (wr_go)
      begin
        o_bvalid <= 1'b1;
        o_bresp  <= (awaddr_r == ptp_ts_pkg::CTRL_OFF || awaddr_r == ptp_ts_pkg::STAT_OFF)
                    ? ptp_ts_pkg::RESP_OK : ptp_ts_pkg::RESP_ERR;
      end
      else if (i_bready)
        o_bvalid <= 1'b0;
    end
  end

  // Control register: clock mode and latency adjust
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tc_r  <= 1'b0;
      lat_r <= ptp_ts_pkg::LAT_RST;
    end
    else if (i_ce && wr_go && awaddr_r == ptp_ts_pkg::CTRL_OFF)
    begin
      if (wstrb_r[0])
        tc_r <= wdata_r[ptp_ts_pkg::TC_BIT];
      if (wstrb_r[1])
        lat_r <= wdata_r[ptp_ts_pkg::LAT_LSB +: 8];
    end
  end

  // Read channel: one read at a time
  assign o_arready = !o_rvalid;
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h0;
      o_rresp  <= ptp_ts_pkg::RESP_OK;
    end
    else if (i_ce)
    begin
      if (i_arvalid && o_arready)
      begin
        o_rvalid <= 1'b1;
        o_rresp  <= ptp_ts_pkg::RESP_OK;
        case (i_araddr)
          ptp_ts_pkg::CTRL_OFF: o_rdata <= {16'h0, lat_r, 7'h0, tc_r};
          ptp_ts_pkg::STAT_OFF: o_rdata <= {tx_cnt_r, rx_cnt_r};
          default:
          begin
            o_rdata <= 32'h0;
            o_rresp <= ptp_ts_pkg::RESP_ERR;
          end
        endcase
      end
      else if (i_rready)
        o_rvalid <= 1'b0;
    end
  end

  // Lane 0 sampling, dead slot leaves the last sample
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      gb_cnt_r <= 6'h00;
      rx_ts_r  <= 80'h0;
    end
    else if (i_ce && i_rx_gb_valid)
    begin
      gb_cnt_r <= (gb_cnt_r == ptp_ts_pkg::GB_LAST) ? 6'h00 : gb_cnt_r + 6'h01;
      if (gb_cnt_r != ptp_ts_pkg::GB_LAST)
        rx_ts_r <= i_rx_timer;
    end
  end

  // Decoded stream out, stamp kept only at frame start
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rx_valid   <= 1'b0;
      o_rx_sop     <= 1'b0;
      o_rx_eop     <= 1'b0;
      o_rx_data    <= 64'h0;
      o_rx_tstamp  <= 80'h0;
      o_rx_pcslane <= 5'h00;
      o_rx_fill    <= 140'h0;
      rx_cnt_r     <= 16'h0;
    end
    else if (i_ce)
    begin
      o_rx_valid <= i_rx_dec_valid;
      o_rx_sop   <= i_rx_dec_valid && i_rx_dec_sop;
      o_rx_eop   <= i_rx_dec_valid && i_rx_dec_eop;
      o_rx_data  <= i_rx_dec_data;
      o_rx_fill  <= i_rx_fill;
      if (i_rx_dec_valid && i_rx_dec_sop)
      begin
        o_rx_tstamp  <= rx_ts_r;
        o_rx_pcslane <= i_rx_dec_lane;
        rx_cnt_r     <= rx_cnt_r + 16'h1;
      end
    end
  end

  // Stamps at the capture points
  assign tx_take  = i_tx_valid && o_tx_in_ready;
  assign sop_take = tx_take && st_r == ptp_ts_pkg::S_IDLE;
  assign comp     = (ptp_ts_pkg::CYCLE_FRAC * {27'h0, i_tx_gb_seq}) >> 5;
  assign ts1_full = i_tx_tod + {56'h0, lat_r, 16'h0};
  assign ts2_full = i_tx_tod + {48'h0, comp};
  assign o_tx_in_ready = st_r == ptp_ts_pkg::S_IDLE || st_r == ptp_ts_pkg::S_LOAD;
  assign wptr     = (st_r == ptp_ts_pkg::S_IDLE) ? 7'h00 : wa_r;
  assign rd_word  = {mem[{ra_r[5:0], 2'h0}], mem[{ra_r[5:0], 2'h1}],
                     mem[{ra_r[5:0], 2'h2}], mem[{ra_r[5:0], 2'h3}]};

  // Field sum and incremental checksum
  always_comb
  begin
    logic [15:0] acc;
    acc = ~{mem[csoff_r], mem[csoff_r + 8'h01]};
    for (int k = 0; k < ptp_ts_pkg::CF_BYTES; k++)
    begin
      cf_old[63 - 8 * k -: 8] = mem[tsoff_r + 8'(k)];
    end
    cf_new = cf_old + ts1_r[63:0];
    for (int i = 0; i < 5; i++)
    begin
      acc = oc_add(acc, ~old_r[79 - 16 * i -: 16]);
      acc = oc_add(acc, new_r[79 - 16 * i -: 16]);
    end
    csum_new = ~acc;
  end

  // Frame store: loading and in-place patching
  always_ff @(posedge i_mclk)
  begin
    if (i_ce)
    begin
      if (tx_take && wptr < ptp_ts_pkg::STORE_WDS)
      begin
        for (int k = 0; k < 4; k++)
        begin
          mem[{wptr[5:0], 2'(k)}] <= i_tx_data[31 - 8 * k -: 8];
        end
      end
      if (st_r == ptp_ts_pkg::S_PATCH)
      begin
        for (int k = 0; k < ptp_ts_pkg::TOD_BYTES; k++)
        begin
          if (!tc_r)
            mem[tsoff_r + 8'(k)] <= ts1_r[79 - 8 * k -: 8];
          else if (k < ptp_ts_pkg::CF_BYTES)
            mem[tsoff_r + 8'(k)] <= cf_new[63 - 8 * k -: 8];
        end
      end
      if (st_r == ptp_ts_pkg::S_CSUM)
      begin
        mem[csoff_r]         <= csum_new[15:8];
        mem[csoff_r + 8'h01] <= csum_new[7:0];
      end
    end
  end

  // Transmit sequencer: load, patch, checksum, send with FCS
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_r <= ptp_ts_pkg::S_IDLE;
      {wa_r, ra_r, op_r, udp_r, tsoff_r, csoff_r} <= 33'h0;
      {ts1_r, old_r, new_r} <= 240'h0;
      crc_r      <= ptp_ts_pkg::CRC_INIT;
      mod_done_r <= 1'b0;
      {o_tx_valid, o_tx_sop, o_tx_eop} <= 3'h0;
      o_tx_data  <= 32'h0;
      tx_cnt_r   <= 16'h0;
    end
    else if (i_ce)
    begin
      {o_tx_valid, o_tx_sop, o_tx_eop} <= 3'h0;
      case (st_r)
        ptp_ts_pkg::S_IDLE:
          if (sop_take)
          begin
            // Latch this frame's command
            op_r       <= i_tx_timestamp_command_op;
            udp_r      <= i_tx_timestamp_command_udp;
            tsoff_r    <= i_tx_timestamp_command_ts_off[7:0];
            csoff_r    <= tc_r ? i_tx_timestamp_command_ts_off[7:0] - ptp_ts_pkg::CF_TO_CSUM
                               : i_tx_timestamp_command_cs_off[7:0];
            ts1_r      <= tc_r ? {16'h0, ts1_full[63:0]} : ts1_full;
            wa_r       <= 7'h01;
            ra_r       <= 7'h00;
            crc_r      <= ptp_ts_pkg::CRC_INIT;
            mod_done_r <= 1'b0;
            if (i_tx_eop)
              st_r <= (i_tx_timestamp_command_op == ptp_ts_pkg::OP_ONE)
                      ? ptp_ts_pkg::S_PATCH : ptp_ts_pkg::S_SEND;
            else
              st_r <= ptp_ts_pkg::S_LOAD;
          end
        ptp_ts_pkg::S_LOAD:
          if (tx_take)
          begin
            if (wa_r < ptp_ts_pkg::STORE_WDS)
              wa_r <= wa_r + 7'h01;
            if (i_tx_eop)
              st_r <= (op_r == ptp_ts_pkg::OP_ONE) ? ptp_ts_pkg::S_PATCH : ptp_ts_pkg::S_SEND;
          end
        ptp_ts_pkg::S_PATCH:
        begin
          // Old bytes (zero in ordinary mode) and new bytes for the checksum step
          old_r      <= tc_r ? {16'h0, cf_old} : 80'h0;
          new_r      <= tc_r ? {16'h0, cf_new} : ts1_r;
          mod_done_r <= !udp_r;
          st_r       <= udp_r ? ptp_ts_pkg::S_CSUM : ptp_ts_pkg::S_SEND;
        end
        ptp_ts_pkg::S_CSUM:
        begin
          mod_done_r <= 1'b1;
          st_r       <= ptp_ts_pkg::S_SEND;
        end
        ptp_ts_pkg::S_SEND:
        begin
          o_tx_valid <= 1'b1;
          if (ra_r < wa_r)
          begin
            o_tx_data <= rd_word;
            o_tx_sop  <= ra_r == 7'h00;
            crc_r     <= crc_w(crc_r, rd_word);
            ra_r      <= ra_r + 7'h01;
          end
          else
          begin
            o_tx_data <= ~{crc_r[7:0], crc_r[15:8], crc_r[23:16], crc_r[31:24]};
            o_tx_eop  <= 1'b1;
            tx_cnt_r  <= tx_cnt_r + 16'h1;
            st_r      <= ptp_ts_pkg::S_IDLE;
          end
        end
        default: st_r <= ptp_ts_pkg::S_IDLE;
      endcase
    end
  end

  // Stamp return to the client, upper bits cleared in transparent mode
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_tx_ts_valid <= 1'b0;
      o_tx_ts       <= 80'h0;
      o_tx_tag      <= 16'h0;
    end
    else if (i_ce)
    begin
      o_tx_ts_valid <= sop_take && i_tx_timestamp_command_op != ptp_ts_pkg::OP_NOP;
      if (sop_take && i_tx_timestamp_command_op == ptp_ts_pkg::OP_TWO)
      begin
        o_tx_ts  <= tc_r ? {16'h0, ts2_full[63:0]} : ts2_full;
        o_tx_tag <= i_tx_timestamp_command_tag;
      end
      else if (sop_take && i_tx_timestamp_command_op == ptp_ts_pkg::OP_ONE)
        o_tx_ts <= tc_r ? {16'h0, ts1_full[63:0]} : ts1_full;
    end
  end

  dead_slot_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $past(i_ce && i_rx_gb_valid && gb_cnt_r == ptp_ts_pkg::GB_LAST) |-> $stable(rx_ts_r))
    else $error("sample taken in dead slot");
  rx_sop_stamp_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $past(i_ce && i_rx_dec_valid && i_rx_dec_sop) |-> o_rx_sop
      && o_rx_pcslane == $past(i_rx_dec_lane) && o_rx_tstamp == $past(rx_ts_r))
    else $error("start stamp or lane wrong");
  fill_out_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $past(i_ce && i_rst_n) |-> o_rx_fill == $past(i_rx_fill))
    else $error("fill level not passed on");
  nop_quiet_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $past(i_ce && sop_take && i_tx_timestamp_command_op == ptp_ts_pkg::OP_NOP)
      |-> !o_tx_ts_valid)
    else $error("stamp returned for no-operation");
  tag_return_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $past(i_ce && sop_take && i_tx_timestamp_command_op == ptp_ts_pkg::OP_TWO)
      |-> o_tx_ts_valid && o_tx_tag == $past(i_tx_timestamp_command_tag))
    else $error("2-step tag missing");
  jitter_comp_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $past(i_ce && sop_take && !tc_r && i_tx_timestamp_command_op == ptp_ts_pkg::OP_TWO)
      |-> o_tx_ts == $past(i_tx_tod) + 80'(($past(i_tx_gb_seq) * ptp_ts_pkg::CYCLE_FRAC) >> 5))
    else $error("2-step stamp not compensated");
  tc_upper_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $past(i_ce && sop_take && tc_r && i_tx_timestamp_command_op != ptp_ts_pkg::OP_NOP)
      |-> o_tx_ts[79:64] == 16'h0)
    else $error("upper stamp bits not zero");
  fcs_after_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_tx_valid && o_tx_sop && op_r == ptp_ts_pkg::OP_ONE |-> mod_done_r)
    else $error("frame sent before patching");
endmodule : ptp_timestamp_unit_100g

/* File: hdl/ptp_ts_pkg.sv */
package ptp_ts_pkg;
  // Register map
  localparam logic [7:0]  CTRL_OFF   = 8'h00;        // Mode and latency adjust
  localparam logic [7:0]  STAT_OFF   = 8'h04;        // Frame counters
  localparam int          TC_BIT     = 0;            // Transparent clock select
  localparam int          LAT_LSB    = 8;            // Latency adjust field base
  localparam logic [7:0]  LAT_RST    = 8'h5a;        // 90 decimal
  localparam logic [1:0]  RESP_OK    = 2'h0;         // OKAY
  localparam logic [1:0]  RESP_ERR   = 2'h2;         // SLVERR
  // Gearbox timing
  localparam logic [5:0]  GB_LAST    = 6'h20;        // Dead slot, one in 33
  localparam int          CYCLE_PS   = 3103;         // Gearbox cycle period, ps
  localparam logic [31:0] CYCLE_FRAC = 32'((CYCLE_PS * 65536) / 1000); // In ns/65536
  // Command encodings
  localparam logic [1:0]  OP_NOP     = 2'h0;         // Not a timing frame
  localparam logic [1:0]  OP_ONE     = 2'h1;         // 1-step insertion
  localparam logic [1:0]  OP_TWO     = 2'h2;         // 2-step capture
  localparam logic [7:0]  CF_TO_CSUM = 8'h0a;        // Checksum sits this far before field
  localparam int          TOD_BYTES  = 10;           // Full time of day
  localparam int          CF_BYTES   = 8;            // Correction field
  localparam logic [6:0]  STORE_WDS  = 7'h40;        // Frame store depth in words
  localparam logic [31:0] CRC_POLY   = 32'hedb88320; // Reflected FCS polynomial
  localparam logic [31:0] CRC_INIT   = 32'hffffffff; // FCS seed
  // Transmit sequencer states
  typedef enum logic [4:0] {
    S_IDLE  = 5'h01,
    S_LOAD  = 5'h02,
    S_PATCH = 5'h04,
    S_CSUM  = 5'h08,
    S_SEND  = 5'h10
  } tx_state_t;
endpackage : ptp_ts_pkg

/* File: test/corr_model.sv */
module corr_model (
  input  wire logic [79:0]  i_ts,
  input  wire logic [4:0]   i_lane,
  input  wire logic [139:0] i_fill,
  input  wire logic [99:0]  i_map,
  input  wire logic [6:0]   i_ref,
  output logic [79:0]       o_ts
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] lane_fill; // Fill of the lane that carried the start
  int         fill_diff; // Reference minus lane fill
  // Find the physical lane, then scale its fill offset to time
  always_comb
  begin
    lane_fill = 7'h00;
    for (int p = 0; p < 20; p++)
      if (i_map[5*p +: 5] == i_lane) lane_fill = i_fill[7*p +: 7];
    fill_diff = int'(i_ref) - int'(lane_fill);
    o_ts = i_ts + 80'(longint'(fill_diff) * longint'(ptp_ts_pkg::CYCLE_FRAC));
  end
endmodule : corr_model

/* File: test/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [79:0] TOD = 80'h00c3_0000_1234_5678_0000; // Transmit time of day
  logic i_mclk = 1'h0, i_rst_n = 1'h0, i_ce = 1'h1;
  logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
  logic i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0, i_arvalid = 1'h0, i_rready = 1'h0;
  logic [31:0] i_wdata = 32'h0, i_tx_data = 32'h0, o_rdata, o_tx_data;
  logic [3:0] i_wstrb = 4'hf;
  logic [1:0] o_bresp, o_rresp, i_tx_timestamp_command_op = 2'h0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic i_rx_gb_valid = 1'h0, i_rx_dec_valid = 1'h0, i_rx_dec_sop = 1'h0, i_rx_dec_eop = 1'h0;
  logic [79:0] i_rx_timer = 80'h0, o_rx_tstamp, i_tx_tod = TOD, o_tx_ts, corr_ts;
  logic [4:0] i_rx_dec_lane = 5'h0, o_rx_pcslane, i_tx_gb_seq = 5'h0;
  logic [63:0] i_rx_dec_data = 64'h0, o_rx_data;
  logic [139:0] i_rx_fill = 140'h0, o_rx_fill;
  logic [99:0] lane_map; // Physical lane to logical lane numbers
  logic o_rx_valid, o_rx_sop, o_rx_eop, o_tx_in_ready, o_tx_valid, o_tx_sop, o_tx_eop;
  logic o_tx_ts_valid, i_tx_valid = 1'h0, i_tx_sop = 1'h0, i_tx_eop = 1'h0;
  logic i_tx_timestamp_command_udp = 1'h0;
  logic [15:0] i_tx_timestamp_command_ts_off = 16'h0, i_tx_timestamp_command_cs_off = 16'h0;
  logic [15:0] i_tx_timestamp_command_tag = 16'h0, o_tx_tag;
  logic [7:0] fb [0:15], eb [0:15]; // Sent and expected frame bytes
  logic [31:0] out_q [$]; // Words seen on the transmit output
  int err_count = 0, samples_checked = 0, cycles = 0, ts_seen = 0;
  ptp_timestamp_unit_100g DUT (
    .i_mclk, .i_rst_n, .i_ce, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
    .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
    .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_rx_gb_valid, .i_rx_timer,
    .i_rx_dec_valid, .i_rx_dec_sop, .i_rx_dec_eop, .i_rx_dec_lane, .i_rx_dec_data,
    .i_rx_fill, .o_rx_valid, .o_rx_sop, .o_rx_eop, .o_rx_data, .o_rx_tstamp,
    .o_rx_pcslane, .o_rx_fill, .i_tx_data, .i_tx_valid, .i_tx_sop, .i_tx_eop,
    .o_tx_in_ready, .i_tx_timestamp_command_op, .i_tx_timestamp_command_udp,
    .i_tx_timestamp_command_ts_off, .i_tx_timestamp_command_cs_off,
    .i_tx_timestamp_command_tag, .i_tx_tod, .i_tx_gb_seq, .o_tx_valid, .o_tx_sop,
    .o_tx_eop, .o_tx_data, .o_tx_ts_valid, .o_tx_ts, .o_tx_tag
  );
  corr_model CORR (.i_ts(o_rx_tstamp), .i_lane(o_rx_pcslane), .i_fill(o_rx_fill),
    .i_map(lane_map), .i_ref(7'h14), .o_ts(corr_ts));
  // Clock
  always #5 i_mclk = ~i_mclk;
  // Output collector and hang guard
  always @(posedge i_mclk)
  begin
    cycles++;
    if (o_tx_valid === 1'h1) out_q.push_back(o_tx_data);
    if (o_tx_ts_valid === 1'h1) ts_seen++;
    if (cycles == 5000)
    begin
      err_count++;
      final_report();
    end
  end
  // Compare and count
  task automatic chk(input string nm, input logic [79:0] exp, input logic [79:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One register write or read; channels released as each is taken
  task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] er);
    logic aw, wr, ar, dn;
    logic [31:0] dt;
    logic [1:0] rs;
    @(posedge i_mclk);
    i_awaddr <= a;
    i_araddr <= a;
    i_wdata <= d;
    i_wstrb <= s;
    {i_awvalid, i_wvalid, i_bready} <= {3{w}};
    {i_arvalid, i_rready} <= {2{!w}};
    do
    begin
      @(negedge i_mclk);
      {aw, wr, ar} = {o_awready, o_wready, o_arready};
      dn = w ? o_bvalid : o_rvalid;
      {dt, rs} = w ? {32'h0, o_bresp} : {o_rdata, o_rresp};
      @(posedge i_mclk);
      if (aw === 1'h1) i_awvalid <= 1'h0;
      if (wr === 1'h1) i_wvalid <= 1'h0;
      if (ar === 1'h1) i_arvalid <= 1'h0;
    end while (dn !== 1'h1);
    {i_bready, i_rready} <= 2'h0;
    if (!w) chk("axi rdata", 80'(d), 80'(dt));
    chk("axi resp", 80'(er), 80'(rs));
  endtask : axi
  // Frame check word over the expected bytes, first byte in the top lane
  function automatic logic [31:0] fcs_of();
    logic [31:0] c;
    c = ptp_ts_pkg::CRC_INIT;
    for (int i = 0; i < 16; i++)
    begin
      c = c ^ {24'h0, eb[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ ptp_ts_pkg::CRC_POLY : c >> 1;
    end
    c = ~c;
    return {c[7:0], c[15:8], c[23:16], c[31:24]};
  endfunction : fcs_of
  // Send a four-word frame with its command, then judge the output
  task automatic tx_frame(input logic [1:0] op, input logic [15:0] tag, input logic [4:0] seq,
                          input logic [79:0] ets);
    logic rd;
    int n0;
    n0 = ts_seen;
    out_q.delete();
    @(posedge i_mclk);
    i_tx_timestamp_command_op <= op;
    i_tx_timestamp_command_ts_off <= 16'h0004;
    i_tx_timestamp_command_cs_off <= 16'h000e;
    i_tx_timestamp_command_tag <= tag;
    i_tx_gb_seq <= seq;
    for (int k = 0; k < 4; k++)
    begin
      i_tx_data <= {fb[4*k], fb[4*k+1], fb[4*k+2], fb[4*k+3]};
      {i_tx_valid, i_tx_sop, i_tx_eop} <= {1'h1, k == 0, k == 3};
      do
      begin
        @(negedge i_mclk);
        rd = o_tx_in_ready;
        @(posedge i_mclk);
      end while (rd !== 1'h1);
    end
    {i_tx_valid, i_tx_sop, i_tx_eop} <= 3'h0;
    for (int k = 0; k < 40 && out_q.size() < 5; k++) @(posedge i_mclk);
    for (int k = 0; k < 4; k++)
      chk("tx word", 80'({eb[4*k], eb[4*k+1], eb[4*k+2], eb[4*k+3]}), 80'(out_q[k]));
    chk("tx fcs", 80'(fcs_of()), 80'(out_q[4]));
    chk("tx stamp pulses", 80'(op != 2'h0), 80'(ts_seen - n0));
    if (op != 2'h0) chk("tx stamp", ets, o_tx_ts);
    if (op == 2'h2) chk("tx tag", 80'(tag), 80'(o_tx_tag));
  endtask : tx_frame
  // Reset values, unmapped and read-only places
  task automatic t_regs();
    axi(1'h0, ptp_ts_pkg::CTRL_OFF, {16'h0, ptp_ts_pkg::LAT_RST, 8'h00}, 4'hf,
        ptp_ts_pkg::RESP_OK);
    axi(1'h0, 8'h08, 32'h0, 4'hf, ptp_ts_pkg::RESP_ERR);
    axi(1'h1, 8'h08, 32'h1, 4'hf, ptp_ts_pkg::RESP_ERR);
    axi(1'h1, ptp_ts_pkg::STAT_OFF, 32'hffff_ffff, 4'hf, ptp_ts_pkg::RESP_OK);
    axi(1'h0, ptp_ts_pkg::STAT_OFF, 32'h0, 4'hf, ptp_ts_pkg::RESP_OK);
  endtask : t_regs
  // 33 gearbox words, the dead slot last, then a start word
  task automatic t_rx();
    for (int k = 0; k < 33; k++)
    begin
      @(posedge i_mclk);
      {i_rx_gb_valid, i_rx_timer} <= {1'h1, 80'h100 + 80'(k)};
    end
    @(posedge i_mclk);
    {i_rx_gb_valid, i_rx_dec_valid, i_rx_dec_sop, i_rx_dec_eop} <= 4'h7;
    {i_rx_dec_lane, i_rx_dec_data} <= {5'h07, 64'h0123_4567_89ab_cdef};
    @(posedge i_mclk);
    {i_rx_dec_valid, i_rx_dec_sop, i_rx_dec_eop} <= 3'h0;
    @(negedge i_mclk);
    chk("rx start", 80'h7, 80'({o_rx_valid, o_rx_sop, o_rx_eop}));
    chk("rx data", 80'h0123_4567_89ab_cdef, 80'(o_rx_data));
    chk("rx stamp", 80'h11f, o_rx_tstamp);
    chk("rx lane", 80'h7, 80'(o_rx_pcslane));
    chk("rx fill lo", i_rx_fill[79:0], o_rx_fill[79:0]);
    chk("rx fill hi", 80'(i_rx_fill[139:80]), 80'(o_rx_fill[139:80]));
    chk("rx corrected", 80'h11f + 80'(5 * ptp_ts_pkg::CYCLE_FRAC), corr_ts);
  endtask : t_rx
  // No-operation and 2-step frames, jitter at two sequence numbers
  task automatic t_plain();
    eb = fb;
    tx_frame(ptp_ts_pkg::OP_NOP, 16'h0, 5'h00, 80'h0);
    tx_frame(ptp_ts_pkg::OP_TWO, 16'hbeef, 5'h00, TOD);
    tx_frame(ptp_ts_pkg::OP_TWO, 16'h0102, 5'h10,
             TOD + 80'((64'(ptp_ts_pkg::CYCLE_FRAC) * 64'h10) >> 5));
  endtask : t_plain
  // 1-step insertion of the latency-adjusted stamp at byte 4, then with checksum at byte 14
  task automatic t_one();
    logic [79:0] st;
    logic [16:0] s;
    st = TOD + (80'(ptp_ts_pkg::LAT_RST) << 16);
    eb = fb;
    for (int i = 0; i < 10; i++) eb[4+i] = st[79-8*i -: 8];
    tx_frame(ptp_ts_pkg::OP_ONE, 16'h0, 5'h00, st);
    s = {1'h0, ~{fb[14], fb[15]}};
    for (int i = 0; i < 5; i++) s = 17'(s[15:0] + 16'(s[16])) + 17'(st[79-16*i -: 16]);
    {eb[14], eb[15]} = ~(s[15:0] + 16'(s[16]));
    i_tx_timestamp_command_udp <= 1'h1;
    tx_frame(ptp_ts_pkg::OP_ONE, 16'h0, 5'h00, st);
    i_tx_timestamp_command_udp <= 1'h0;
  endtask : t_one
  // Transparent mode returns 64 bits, then the frame counters
  task automatic t_tc();
    axi(1'h1, ptp_ts_pkg::CTRL_OFF, 32'h0000_5a01, 4'h3, ptp_ts_pkg::RESP_OK);
    axi(1'h0, ptp_ts_pkg::CTRL_OFF, 32'h0000_5a01, 4'hf, ptp_ts_pkg::RESP_OK);
    eb = fb;
    tx_frame(ptp_ts_pkg::OP_TWO, 16'h0a0b, 5'h00, {16'h0, TOD[63:0]});
    axi(1'h0, ptp_ts_pkg::STAT_OFF, 32'h0006_0001, 4'hf, ptp_ts_pkg::RESP_OK);
  endtask : t_tc
  // Verdict and end of run
  task automatic final_report();
    if (err_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  // Main sequence
  initial
  begin
    for (int p = 0; p < 20; p++)
      {i_rx_fill[7*p +: 7], lane_map[5*p +: 5]} = {7'(p + 3), 5'(19 - p)};
    for (int i = 0; i < 16; i++) fb[i] = 8'(i * 17 + 3);
    repeat (4) @(posedge i_mclk);
    i_rst_n <= 1'h1;
    t_regs();
    t_rx();
    t_plain();
    t_one();
    t_tc();
    final_report();
  end
endmodule : tb_top
